//--- logic/cots_out_stage.sv
`timescale 1ns/10ps
`default_nettype none
module cots_out_stage #(
    parameter int DT_W = cots_pkg::COTS_DT_W
) (
    input  wire  logic            clk_sys,
    input  wire  logic            rst,
    input  wire  logic            chan_reference,
    input  wire  logic            chan_out_enable,
    input  wire  logic            chan_comp_out_enable,
    input  wire  logic            chan_polarity,
    input  wire  logic            comp_polarity,
    input  wire  logic            chan_idle_level,
    input  wire  logic            comp_idle_level,
    input  wire  logic            main_output_enable,
    input  wire  logic            run_off_state_select,
    input  wire  logic            idle_off_state_select,
    input  wire  logic [DT_W-1:0] dead_time,
    output logic                  chan_output,
    output logic                  comp_output,
    output logic                  chan_pad_enable,
    output logic                  comp_pad_enable
);
    import cots_pkg::*;

    logic            ref_q_r;
    logic [DT_W-1:0] dt_cnt_r;
    logic [DT_W-1:0] idle_cnt_r;
    cots_idle_t      st_r;
    logic            dt_ok;
    logic            idle_go;

    if (DT_W < 1 || DT_W > COTS_W) begin : g_chk
        $error("cots_out_stage: DT_W out of range");
    end

    assign dt_ok = (dt_cnt_r == '0);
    assign idle_go = (chan_out_enable || chan_comp_out_enable)
                   && ((chan_polarity ^ chan_idle_level)
                   ^ (comp_polarity ^ comp_idle_level));

    // Reference edge restarts the gap; both sides held inactive meanwhile
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            ref_q_r  <= 1'b0;
            dt_cnt_r <= '0;
        end else begin
            ref_q_r <= chan_reference;
            if (chan_reference != ref_q_r) begin
                dt_cnt_r <= dead_time;
            end else if (!dt_ok) begin
                dt_cnt_r <= DT_W'(dt_cnt_r - 1'b1);
            end
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            st_r       <= COTS_ST_RUN;
            idle_cnt_r <= '0;
        end else begin
            case (st_r)
                COTS_ST_RUN: begin
                    if (!main_output_enable) begin
                        st_r       <= COTS_ST_FORCED;
                        idle_cnt_r <= dead_time;
                    end
                end
                COTS_ST_FORCED: begin
                    if (main_output_enable) begin
                        st_r <= COTS_ST_RUN;
                    end else if (idle_go) begin
                        if (idle_cnt_r == '0) begin
                            st_r <= COTS_ST_IDLE;
                        end else begin
                            idle_cnt_r <= DT_W'(idle_cnt_r - 1'b1);
                        end
                    end
                end
                COTS_ST_IDLE: begin
                    if (main_output_enable) begin
                        st_r <= COTS_ST_RUN;
                    end
                end
                default: begin
                    st_r <= COTS_ST_RUN;
                end
            endcase
        end
    end

    // Not registered: forcing must not wait for a clock edge
    always_comb begin
        chan_output     = 1'b0;
        comp_output     = 1'b0;
        chan_pad_enable = 1'b0;
        comp_pad_enable = 1'b0;
        if (!main_output_enable) begin
            chan_pad_enable = idle_off_state_select;
            comp_pad_enable = idle_off_state_select;
            if (st_r == COTS_ST_IDLE) begin
                chan_output = chan_idle_level;
                comp_output = comp_idle_level;
            end else begin
                chan_output = chan_polarity;
                comp_output = comp_polarity;
            end
        end else begin
            case ({chan_out_enable, chan_comp_out_enable})
                2'b11: begin
                    chan_output = (ref_q_r & dt_ok) ^ chan_polarity;
                    comp_output = (~ref_q_r & dt_ok) ^ comp_polarity;
                    chan_pad_enable = 1'b1;
                    comp_pad_enable = 1'b1;
                end
                2'b10: begin
                    chan_output = chan_reference ^ chan_polarity;
                    chan_pad_enable = 1'b1;
                    comp_output = run_off_state_select & comp_polarity;
                    comp_pad_enable = run_off_state_select;
                end
                2'b01: begin
                    comp_output = chan_reference ^ comp_polarity;
                    comp_pad_enable = 1'b1;
                    chan_output = run_off_state_select & chan_polarity;
                    chan_pad_enable = run_off_state_select;
                end
                default: begin
                    chan_output = run_off_state_select & chan_polarity;
                    comp_output = run_off_state_select & comp_polarity;
                end
            endcase
        end
    end
endmodule
`default_nettype wire

//--- logic/cots_prescaler.sv
`timescale 1ns/10ps
`default_nettype none
module cots_prescaler #(
    parameter int W = cots_pkg::COTS_W
) (
    input  wire  logic         clk_sys,
    input  wire  logic         rst,
    input  wire  logic         run,
    input  wire  logic         clear,
    input  wire  logic [W-1:0] div,
    output logic               tick
);
    import cots_pkg::*;

    logic [W-1:0] pcnt_r;

    if (W < 1 || W > COTS_W) begin : g_chk
        $error("cots_prescaler: W out of range");
    end

    assign tick = run && (pcnt_r == div);

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            pcnt_r <= '0;
        end else if (clear) begin
            pcnt_r <= '0;
        end else if (run) begin
            pcnt_r <= tick ? '0 : W'(pcnt_r + 1'b1);
        end
    end
endmodule
`default_nettype wire

//--- logic/cots_timebase.sv
// Design decision made here: register access over AHB-Lite.
`timescale 1ns/10ps
`default_nettype none
module cots_timebase #(
    parameter int CNT_W = cots_pkg::COTS_W
) (
    input  wire  logic                       clk_sys,
    input  wire  logic                       rst,
    input  wire  logic                       hsel,
    input  wire  logic [31:0]                haddr,
    input  wire  logic [1:0]                 htrans,
    input  wire  logic                       hwrite,
    input  wire  logic [2:0]                 hsize,
    input  wire  logic [31:0]                hwdata,
    input  wire  logic                       hready,
    output logic                             hreadyout,
    output logic [31:0]                      hrdata,
    output logic                             hresp,
    input  wire  logic                       chan_reference,
    output logic                             chan_output,
    output logic                             comp_output,
    output logic                             chan_pad_enable,
    output logic                             comp_pad_enable,
    output logic                             update_event,
    output logic [cots_pkg::COTS_W-1:0]      count_value
);
    import cots_pkg::*;

    logic                 dp_wr_r;
    logic [COTS_AW-1:0]   dp_addr_r;
    logic                 hreadyout_r;
    logic [31:0]          hrdata_r;
    logic                 hresp_r;
    logic                 cen_r;
    logic                 ug_r;
    logic                 ce_r;
    logic                 cp_r;
    logic                 cne_r;
    logic                 cnp_r;
    logic                 oi_r;
    logic                 oin_r;
    logic                 moe_r;
    logic                 run_off_state_select_r;
    logic                 idle_off_state_select_r;
    logic [COTS_DT_W-1:0] dt_r;
    logic [CNT_W-1:0]     cnt_r;
    logic [CNT_W-1:0]     psc_r;
    logic [CNT_W-1:0]     psc_act_r;
    logic [CNT_W-1:0]     arr_r;
    logic [CNT_W-1:0]     arr_act_r;
    logic                 uif_r;
    logic                 upd_r;
    logic                 ap;
    logic                 run;
    logic                 tick;
    logic                 ovf;
    logic                 upd_ev;
    logic                 cnt_wr;
    logic                 idle_cond;
    logic [31:0]          rd_word;

    if (CNT_W != COTS_W) begin : g_chk
        $error("cots_timebase: CNT_W must match register width");
    end

    function automatic logic wr_hit(input logic [COTS_AW-1:0] off);
        wr_hit = dp_wr_r && (dp_addr_r == off);
    endfunction

    function automatic logic [31:0] pad16(input logic [CNT_W-1:0] v);
        pad16 = {{(32 - CNT_W){1'b0}}, v};
    endfunction

    // Only NONSEQ and SEQ transfers carry a request
    assign ap = hsel && hready && htrans[1];
    assign cnt_wr = wr_hit(COTS_OFF_CNT);
    assign run = cen_r && (arr_r != '0);
    assign ovf = tick && (cnt_r == arr_act_r);
    assign upd_ev = ovf || ug_r;
    assign idle_cond = (cp_r ^ oi_r) ^ (cnp_r ^ oin_r);

    assign hreadyout = hreadyout_r;
    assign hrdata = hrdata_r;
    assign hresp = hresp_r;
    assign update_event = upd_r;
    assign count_value = cnt_r;

    always_comb begin
        rd_word = COTS_RST_WORD;
        case (haddr[COTS_AW-1:0])
            COTS_OFF_CTRL: begin
                rd_word[COTS_CTRL_CEN] = cen_r;
            end
            COTS_OFF_OUTC: begin
                rd_word[COTS_OUT_CE] = ce_r;
                rd_word[COTS_OUT_CP] = cp_r;
                rd_word[COTS_OUT_CNE] = cne_r;
                rd_word[COTS_OUT_CNP] = cnp_r;
                rd_word[COTS_OUT_OI] = oi_r;
                rd_word[COTS_OUT_OIN] = oin_r;
                rd_word[COTS_OUT_MOE] = moe_r;
                rd_word[COTS_OUT_RUN_OFF_STATE_SELECT] = run_off_state_select_r;
                rd_word[COTS_OUT_IDLE_OFF_STATE_SELECT] = idle_off_state_select_r;
                rd_word[COTS_OUT_DT +: COTS_DT_W] = dt_r;
            end
            COTS_OFF_STAT: begin
                rd_word[COTS_STAT_UIF] = uif_r;
                rd_word[COTS_STAT_RUN] = run;
            end
            COTS_OFF_CNT: begin
                rd_word = pad16(cnt_r);
            end
            COTS_OFF_PSC: begin
                rd_word = pad16(psc_r);
            end
            COTS_OFF_ARR: begin
                rd_word = pad16(arr_r);
            end
            default: begin
                rd_word = COTS_RST_WORD;
            end
        endcase
    end

    // Zero wait states; a read answers from the address phase snapshot
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            dp_wr_r     <= 1'b0;
            dp_addr_r   <= '0;
            hreadyout_r <= 1'b1;
            hresp_r     <= COTS_HRESP_OKAY;
            hrdata_r    <= COTS_RST_WORD;
        end else begin
            dp_wr_r     <= ap && hwrite;
            dp_addr_r   <= haddr[COTS_AW-1:0];
            hreadyout_r <= 1'b1;
            hresp_r     <= COTS_HRESP_OKAY;
            if (ap && !hwrite) begin
                hrdata_r <= rd_word;
            end
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            cen_r <= 1'b0;
            ug_r  <= 1'b0;
        end else begin
            ug_r <= wr_hit(COTS_OFF_CTRL) && hwdata[COTS_CTRL_UG];
            if (wr_hit(COTS_OFF_CTRL)) begin
                cen_r <= hwdata[COTS_CTRL_CEN];
            end
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            ce_r   <= 1'b0;
            cp_r   <= 1'b0;
            cne_r  <= 1'b0;
            cnp_r  <= 1'b0;
            oi_r   <= 1'b0;
            oin_r  <= 1'b0;
            moe_r  <= 1'b0;
            run_off_state_select_r <= 1'b0;
            idle_off_state_select_r <= 1'b0;
            dt_r   <= COTS_RST_DT;
        end else if (wr_hit(COTS_OFF_OUTC)) begin
            ce_r   <= hwdata[COTS_OUT_CE];
            cp_r   <= hwdata[COTS_OUT_CP];
            cne_r  <= hwdata[COTS_OUT_CNE];
            cnp_r  <= hwdata[COTS_OUT_CNP];
            oi_r   <= hwdata[COTS_OUT_OI];
            oin_r  <= hwdata[COTS_OUT_OIN];
            moe_r  <= hwdata[COTS_OUT_MOE];
            run_off_state_select_r <= hwdata[COTS_OUT_RUN_OFF_STATE_SELECT];
            idle_off_state_select_r <= hwdata[COTS_OUT_IDLE_OFF_STATE_SELECT];
            dt_r   <= hwdata[COTS_OUT_DT +: COTS_DT_W];
        end
    end

    // Software write to the counter wins over counting
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            cnt_r <= COTS_RST_CNT;
        end else if (cnt_wr) begin
            cnt_r <= hwdata[CNT_W-1:0];
        end else if (ug_r) begin
            cnt_r <= '0;
        end else if (tick) begin
            cnt_r <= ovf ? '0 : CNT_W'(cnt_r + 1'b1);
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            psc_r <= COTS_RST_PSC;
            arr_r <= COTS_RST_ARR;
        end else begin
            if (wr_hit(COTS_OFF_PSC)) begin
                psc_r <= hwdata[CNT_W-1:0];
            end
            if (wr_hit(COTS_OFF_ARR)) begin
                arr_r <= hwdata[CNT_W-1:0];
            end
        end
    end

    // Active copies move only on an update event
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            psc_act_r <= COTS_RST_PSC;
            arr_act_r <= COTS_RST_ARR;
        end else if (upd_ev) begin
            psc_act_r <= psc_r;
            arr_act_r <= arr_r;
        end
    end

    // A new event beats a clear in the same cycle
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            uif_r <= 1'b0;
            upd_r <= 1'b0;
        end else begin
            upd_r <= upd_ev;
            if (upd_ev) begin
                uif_r <= 1'b1;
            end else if (wr_hit(COTS_OFF_STAT) && hwdata[COTS_STAT_UIF]) begin
                uif_r <= 1'b0;
            end
        end
    end

    cots_prescaler #(
        .W(CNT_W)
    ) u_psc (
        .clk_sys (clk_sys),
        .rst     (rst),
        .run     (run),
        .clear   (ug_r),
        .div     (psc_act_r),
        .tick    (tick)
    );

    cots_out_stage #(
        .DT_W(COTS_DT_W)
    ) u_out (
        .clk_sys               (clk_sys),
        .rst                   (rst),
        .chan_reference        (chan_reference),
        .chan_out_enable       (ce_r),
        .chan_comp_out_enable  (cne_r),
        .chan_polarity         (cp_r),
        .comp_polarity         (cnp_r),
        .chan_idle_level       (oi_r),
        .comp_idle_level       (oin_r),
        .main_output_enable    (moe_r),
        .run_off_state_select  (run_off_state_select_r),
        .idle_off_state_select (idle_off_state_select_r),
        .dead_time             (dt_r),
        .chan_output           (chan_output),
        .comp_output           (comp_output),
        .chan_pad_enable       (chan_pad_enable),
        .comp_pad_enable       (comp_pad_enable)
    );

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);

    sequence s_moe_drop;
        $fell(moe_r);
    endsequence

    sequence s_idle_arm;
        !moe_r && (ce_r || cne_r) && idle_cond && (dt_r == '0);
    endsequence

    a_chan_only: assert property (
        moe_r && ce_r && !cne_r |->
            chan_output == (chan_reference ^ cp_r) && chan_pad_enable)
        else $error("main output wrong in single mode");

    a_comp_only: assert property (
        moe_r && cne_r && !ce_r |->
            comp_output == (chan_reference ^ cnp_r) && comp_pad_enable)
        else $error("complement output wrong in single mode");

    a_both_pads: assert property (
        moe_r && ce_r && cne_r |-> chan_pad_enable && comp_pad_enable)
        else $error("pads not enabled in complementary mode");

    a_no_overlap: assert property (
        moe_r && ce_r && cne_r |->
            !((chan_output ^ cp_r) && (comp_output ^ cnp_r)))
        else $error("both outputs active together");

    a_run_off_low: assert property (
        moe_r && !run_off_state_select_r && !ce_r |-> !chan_output && !chan_pad_enable)
        else $error("disabled output not released");

    a_off_state: assert property (
        moe_r && run_off_state_select_r && ce_r && !cne_r |->
            comp_output == cnp_r && comp_pad_enable)
        else $error("complement not in off-state");

    a_all_off: assert property (
        moe_r && run_off_state_select_r && !ce_r && !cne_r |->
            chan_output == cp_r && comp_output == cnp_r
            && !chan_pad_enable && !comp_pad_enable)
        else $error("outputs wrong with both disabled");

    a_idle_release: assert property (
        s_moe_drop and !idle_off_state_select_r |->
            chan_output == cp_r && comp_output == cnp_r
            && !chan_pad_enable && !comp_pad_enable)
        else $error("idle forcing with pads off failed");

    a_idle_drive: assert property (
        s_moe_drop and idle_off_state_select_r |->
            chan_output == cp_r && comp_output == cnp_r
            && chan_pad_enable && comp_pad_enable)
        else $error("idle forcing with pads on failed");

    a_idle_level: assert property (
        s_idle_arm [*3] |->
            chan_output == oi_r && comp_output == oin_r)
        else $error("idle levels not reached");

    a_polarity: assert property (
        moe_r && ce_r && !cne_r && !chan_reference |-> chan_output == cp_r)
        else $error("inactive level not equal to polarity");

    a_psc_gap: assert property (
        tick && !upd_ev && psc_act_r != '0 |=> !tick)
        else $error("prescaler ticked too early");

    a_psc_hold: assert property (
        !upd_ev |=> $stable(psc_act_r))
        else $error("active prescaler changed without update");

    a_arr_load: assert property (
        upd_ev |=> arr_act_r == $past(arr_r))
        else $error("active reload not loaded on update");

    a_arr_zero: assert property (
        arr_r == '0 && !cnt_wr && !ug_r |=> $stable(cnt_r))
        else $error("counter moved with zero reload");

endmodule
`default_nettype wire

//--- shared/cots_pkg.sv
// Contract
// - Only main enabled: main pin follows reference xor its polarity, pad on.
// - Only complement enabled: complement pin is reference xor its polarity, pad on.
// - Both enabled: main and inverted reference, polarity and dead-time, pads on.
// - Run off-state clear: a disabled output is 0 with its pad off.
// - Run off-state set, partner enabled: disabled output at polarity, pad on.
// - Run off-state set, both disabled: outputs at polarity, pads off.
// - Main enable and idle select clear: at once polarity levels, pads off.
// - Main enable clear, idle select set: at once polarity levels, pads on.
// - Then, clocked and enabled, idle levels after dead-time if mismatch term nonzero.
// - Counter clock is prescaler clock divided by prescale value plus one.
// - Prescale writes are buffered and copied to active on update event.
// - Reload register resets to all ones and feeds the active reload.
// - A zero reload value stops the counter.
// - Polarity bit 0 means active high, 1 means active low.
`default_nettype none
package cots_pkg;

    localparam int COTS_W = 16;
    localparam int COTS_DT_W = 8;
    localparam int COTS_AW = 8;

    localparam logic [7:0] COTS_OFF_CTRL = 8'h00;
    localparam logic [7:0] COTS_OFF_OUTC = 8'h04;
    localparam logic [7:0] COTS_OFF_STAT = 8'h08;
    localparam logic [7:0] COTS_OFF_CNT  = 8'h24;
    localparam logic [7:0] COTS_OFF_PSC  = 8'h28;
    localparam logic [7:0] COTS_OFF_ARR  = 8'h2c;

    localparam int COTS_CTRL_CEN = 0;
    localparam int COTS_CTRL_UG  = 1;
    localparam int COTS_OUT_CE   = 0;
    localparam int COTS_OUT_CP   = 1;
    localparam int COTS_OUT_CNE  = 2;
    localparam int COTS_OUT_CNP  = 3;
    localparam int COTS_OUT_OI   = 4;
    localparam int COTS_OUT_OIN  = 5;
    localparam int COTS_OUT_MOE  = 8;
    localparam int COTS_OUT_RUN_OFF_STATE_SELECT = 9;
    localparam int COTS_OUT_IDLE_OFF_STATE_SELECT = 10;
    localparam int COTS_OUT_DT   = 16;
    localparam int COTS_STAT_UIF = 0;
    localparam int COTS_STAT_RUN = 1;

    localparam logic [15:0] COTS_RST_CNT  = 16'h0000;
    localparam logic [15:0] COTS_RST_PSC  = 16'h0000;
    localparam logic [15:0] COTS_RST_ARR  = 16'hffff;
    localparam logic [31:0] COTS_RST_WORD = 32'h0000_0000;
    localparam logic [7:0]  COTS_RST_DT   = 8'h00;

    localparam logic [1:0] COTS_HTRANS_NONSEQ = 2'h2;
    localparam logic       COTS_HRESP_OKAY    = 1'b0;

    typedef enum logic [1:0] {
        COTS_ST_RUN    = 2'b00,
        COTS_ST_FORCED = 2'b01,
        COTS_ST_IDLE   = 2'b10
    } cots_idle_t;

endpackage
`default_nettype wire

//--- verification/cots_switch_model.sv
`timescale 1ns/10ps
`default_nettype none
module cots_switch_model (
    input  wire logic clk_sys,
    input  wire logic hi_in,
    input  wire logic lo_in,
    input  wire logic hi_en,
    input  wire logic lo_en,
    input  wire logic hi_pol,
    input  wire logic lo_pol,
    output var  int   overlaps
);
    // Released pads are pulled low, so they never count as on
    wire logic hi_on = hi_en & (hi_in ^ hi_pol);
    wire logic lo_on = lo_en & (lo_in ^ lo_pol);
    int n_ovl = 0;
    assign overlaps = n_ovl;
    always @(posedge clk_sys) begin
        if (hi_on && lo_on) n_ovl <= n_ovl + 1;
    end
endmodule
`default_nettype wire

//--- verification/tb.sv
`timescale 1ns/10ps
`default_nettype none
module tb;
    import cots_pkg::*;
    logic             clk_sys, rst, hsel, hwrite, chan_reference, rd_ph;
    logic             cp, cnp;
    logic [31:0]      haddr, hwdata, w, ex;
    logic [1:0]       htrans;
    logic [2:0]       hsize;
    wire logic [31:0] hrdata;
    wire logic        hready, hresp, co, no, cpe, npe, upd;
    wire logic [15:0] cnt;
    int               n_fail, n_checks, seed, ovl, k, n;
    logic [31:0]      q[$];

    cots_timebase i_cots_timebase (.clk_sys, .rst, .hsel, .haddr, .htrans,
        .hwrite, .hsize, .hwdata, .hready, .hreadyout(hready), .hrdata,
        .hresp, .chan_reference, .chan_output(co), .comp_output(no),
        .chan_pad_enable(cpe), .comp_pad_enable(npe), .update_event(upd),
        .count_value(cnt));
    cots_switch_model i_cots_switch_model (.clk_sys, .hi_in(co),
        .lo_in(no), .hi_en(cpe), .lo_en(npe), .hi_pol(cp), .lo_pol(cnp),
        .overlaps(ovl));

    initial begin
        clk_sys = 0;
        forever #50 clk_sys = ~clk_sys;
    end

    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] s);
        n_checks++;
        if (s !== e) begin
            n_fail++;
            $display("BAD %s exp %h got %h", nm, e, s);
        end
    endtask

    task bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1;
        htrans <= COTS_HTRANS_NONSEQ;
        hwrite <= wr;
        haddr <= {24'h00_0000, a};
        do @(posedge clk_sys); while (hready !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        rd_ph <= !wr;
        if (!wr) q.push_back(d);
        do @(posedge clk_sys); while (hready !== 1'b1);
        rd_ph <= 0;
    endtask

    // Read results are judged here, in issue order
    always @(posedge clk_sys) begin
        if (rd_ph && hready === 1'b1) begin
            ex = q.pop_front();
            chk("hrdata", ex, hrdata);
            chk("hresp", 32'(COTS_HRESP_OKAY), 32'(hresp));
        end
    end

    function automatic logic [3:0] outx(input logic [10:0] c, input logic r);
        logic a, b, pa, pb;
        if (!c[8]) return {c[1], c[3], c[10], c[10]};
        a = c[0] ? r ^ c[1] : c[9] & c[1];
        b = c[2] ? r ^ c[3] : c[9] & c[3];
        pa = c[0] | (c[9] & c[2]);
        pb = c[2] | (c[9] & c[0]);
        return {a, b, pa, pb};
    endfunction

    task oc(input logic [3:0] e);
        #1;
        chk("pins", 32'(e), 32'({co, no, cpe, npe}));
        @(posedge clk_sys);
    endtask

    task per;
        n = 0;
        do begin
            @(posedge clk_sys);
            #1;
            n++;
        end while (upd !== 1'b1 && n < 100);
    endtask

    task report_and_stop;
        $display("checks %0d n_fail %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    initial begin
        #3000000;
        n_fail++;
        report_and_stop();
    end

    initial begin
        {hsel, hwrite, rd_ph, cp, cnp, chan_reference} = 0;
        {haddr, hwdata, htrans} = 0;
        hsize = 3'h2;
        seed = 32'h465f;
        n_fail = 0;
        n_checks = 0;
        rst = 1;
        repeat (12) @(posedge clk_sys);
        rst <= 0;
        bus(0, COTS_OFF_ARR, 32'h0000_ffff);
        bus(0, COTS_OFF_PSC, 32'h0000_0000);
        w = 32'($random(seed) & 16'hffff);
        bus(1, COTS_OFF_CNT, w);
        bus(0, COTS_OFF_CNT, w);
        bus(1, 8'h40, 32'h0000_1234);
        bus(0, 8'h40, 32'h0000_0000);
        // Idle bits copy the polarity bits, so the idle mismatch term stays zero
        for (k = 0; k < 128; k++) begin
            w = {21'h0, k[6:4], 2'b0, k[3], k[1], k[3:0]};
            if ((k[0] & k[2]) || (!(k[0] | k[2]) && (k[1] | k[3]))) continue;
            chan_reference <= 1'($random(seed));
            bus(1, COTS_OFF_OUTC, w);
            // Switch polarity moves only once the write has landed
            cp <= k[1];
            cnp <= k[3];
            oc(outx(w[10:0], chan_reference));
        end
        bus(1, COTS_OFF_OUTC, 32'h0003_0105);
        cp <= 0;
        cnp <= 0;
        repeat (6) begin
            repeat (8) @(posedge clk_sys);
            chan_reference <= ~chan_reference;
        end
        repeat (8) @(posedge clk_sys);
        oc({chan_reference, ~chan_reference, 2'b11});
        chk("overlap", 0, ovl);
        bus(1, COTS_OFF_OUTC, 32'h0003_0003);
        cp <= 1;
        oc(4'b1000);
        repeat (3) @(posedge clk_sys);
        oc(4'b1000);
        oc(4'b0000);
        bus(1, COTS_OFF_OUTC, 32'h0000_0103);
        bus(1, COTS_OFF_OUTC, 32'h0000_0003);
        oc(4'b1000);
        oc(4'b1000);
        oc(4'b0000);
        bus(1, COTS_OFF_ARR, 32'h0000_0004);
        bus(1, COTS_OFF_CTRL, 32'h0000_0003);
        per();
        per();
        chk("period", 5, n);
        chk("count", 0, 32'(cnt));
        bus(1, COTS_OFF_PSC, 32'h0000_0002);
        per();
        chk("buffered", 1, 32'(n <= 5));
        per();
        chk("period", 15, n);
        bus(1, COTS_OFF_ARR, 32'h0000_0000);
        bus(1, COTS_OFF_CTRL, 32'h0000_0003);
        bus(1, COTS_OFF_CNT, 32'h0000_0005);
        repeat (3) @(posedge clk_sys);
        bus(0, COTS_OFF_CNT, 32'h0000_0005);
        repeat (20) @(posedge clk_sys);
        bus(0, COTS_OFF_CNT, 32'h0000_0005);
        report_and_stop();
    end
endmodule
`default_nettype wire
